// ==== src/msc_consts.svh ====
// Constants for the motion sequence command core
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_CLK_HZ        50000000
`define MSC_MS_PER_S      1000
`define MSC_CYC_PER_MS    (`MSC_CLK_HZ / `MSC_MS_PER_S)
`define MSC_DLY_MS_MIN    32'd1
`define MSC_DLY_MS_MAX    32'd99999999
`define MSC_POS_LIMIT     32'sd9999999
`define MSC_DIST_MAX      24'd9999999
`define MSC_SEQ_NUM_MAX   6'd49
`define MSC_NAME_LEN      8
`define MSC_SEQ_SLOTS     64
`define MSC_STACK_DEPTH   8
`define MSC_MEM_TOTAL     16'h2000
`define MSC_ANS_YES       8'h59
`define MSC_ANS_YES_LC    8'h79
`endif

// ==== src/msc_pkg.sv ====
// Types for the motion sequence command core
`default_nettype none
package msc_pkg;
	typedef enum logic [3:0] {
		MSC_OP_NONE    = 4'h0,
		MSC_OP_CALL    = 4'h1,
		MSC_OP_RETURN  = 4'h2,
		MSC_OP_MEMREP  = 4'h3,
		MSC_OP_DLCLR   = 4'h4,
		MSC_OP_WIPE    = 4'h5,
		MSC_OP_RESUME  = 4'h6,
		MSC_OP_COPY    = 4'h7,
		MSC_OP_POSCHK  = 4'h8,
		MSC_OP_DIST    = 4'h9,
		MSC_OP_DIR     = 4'ha,
		MSC_OP_DELAY   = 4'hb,
		MSC_OP_DELETE  = 4'hc
	} msc_op_t;
	typedef enum logic [2:0] {
		MSC_ST_IDLE    = 3'b000,
		MSC_ST_CONFIRM = 3'b001,
		MSC_ST_DELAY   = 3'b011,
		MSC_ST_PCHK    = 3'b010,
		MSC_ST_DONE    = 3'b110
	} msc_state_t;
	typedef struct packed {
		msc_op_t      op;
		logic         from_seq;
		logic         in_cond;
		logic         neg;
		logic [5:0]   seq_a;
		logic [5:0]   seq_b;
		logic [31:0]  value;
	} msc_cmd_t;
	typedef struct packed {
		logic [5:0]   seq;
		logic [7:0]   step;
	} msc_frame_t;
	typedef struct packed {
		logic signed [31:0] value;
		logic               text_free;
		logic               prompt;
		logic               valid;
	} msc_resp_t;
endpackage : msc_pkg
`default_nettype wire

// ==== src/msc_core.sv ====
// Command interpreter core of the stepping motor controller
// Function
// R1: Called sequence runs, then caller resumes at the step after the call.
// R2: Free memory report, immediate only, returns bytes left and bytes-free text.
// R3: Display-loop clear stops periodic display, in both modes.
// R4: Wipe erases sequences, variables and restores defaults; immediate only.
// R5: Wipe first prompts yes/no and waits for the answer.
// R6: Resume, immediate only, restarts interrupted work with remaining part.
// R7: Copy keeps source; existing destination needs overwrite confirmation.
// R8: Position check is encoder times motor over encoder resolution minus position.
// R9: Position check is signed when queried, absolute inside a conditional.
// R10: Distance 0 to 9999999 steps; a sign also sets direction, minus CCW.
// R11: Direction setting steers the following index move.
// R12: Delay holds next step 0.001 to 99999.999 seconds, literal or variable.
// R13: Delay only acts from a stored sequence in program mode.
// R14: Delete confirms, then removes the sequence permanently.
// R15: Host names a sequence by number 0 to 49 or name of 8 characters.
// R16: Encoder resolution is counts per shaft revolution, 0 to 65535.
// R17: Only a yes answer proceeds; anything else leaves storage unchanged.
// R18: Return stack keeps caller positions; a return pops the latest.
`include "msc_consts.svh"
`default_nettype none
module msc_core (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             cmd_valid_in,
	input  wire msc_pkg::msc_cmd_t cmd_in,
	output logic                  cmd_ready_out,
	input  wire logic             answer_valid_in,
	input  wire logic [7:0]       answer_char_in,
	input  wire logic [7:0]       cur_step_in,
	input  wire logic signed [31:0] encoder_counter_in,
	input  wire logic signed [31:0] position_counter_in,
	input  wire logic [15:0]      motor_resolution_in,
	input  wire logic [15:0]      encoder_resolution_in,
	input  wire logic             interrupted_in,
	input  wire logic [15:0]      mem_used_in,
	output msc_pkg::msc_resp_t    resp_out,
	output msc_pkg::msc_frame_t   jump_out,
	output logic                  jump_valid_out,
	output logic                  stack_err_out,
	output logic                  display_loop_on_out,
	input  wire logic             display_loop_set_in,
	output logic                  wipe_out,
	output logic                  copy_out,
	output logic                  delete_out,
	output logic [5:0]            store_src_out,
	output logic [5:0]            store_dst_out,
	input  wire logic [63:0]      seq_exists_in,
	output logic                  resume_out,
	output logic [23:0]           distance_out,
	output logic                  dir_ccw_out,
	output logic                  step_hold_out
);
	import msc_pkg::*;

	msc_state_t state_r, state_nxt;
	msc_cmd_t   pend_r;
	msc_frame_t stack_r [`MSC_STACK_DEPTH];
	logic [3:0] sp_r;
	logic [31:0] ms_left_r;
	logic [15:0] tick_r;
	logic signed [63:0] prod_r;

	wire idle_w      = (state_r == MSC_ST_IDLE);
	wire take_w      = cmd_valid_in && idle_w;
	wire imm_w       = !cmd_in.from_seq;
	wire ans_evt_w   = answer_valid_in;
	wire ans_yes_w   = (answer_char_in == `MSC_ANS_YES) ||
	                   (answer_char_in == `MSC_ANS_YES_LC);
	wire tick_end_w  = (tick_r == 16'(`MSC_CYC_PER_MS - 1));
	wire stack_full_w  = (sp_r == 4'(`MSC_STACK_DEPTH));
	wire stack_empty_w = (sp_r == 4'h0);
	wire need_conf_w = (cmd_in.op == MSC_OP_WIPE) ||
	                   (cmd_in.op == MSC_OP_DELETE) ||
	                   ((cmd_in.op == MSC_OP_COPY) &&
	                    seq_exists_in[cmd_in.seq_b]);
	wire [31:0] dly_w = (cmd_in.value < `MSC_DLY_MS_MIN) ? `MSC_DLY_MS_MIN :
	                    (cmd_in.value > `MSC_DLY_MS_MAX) ? `MSC_DLY_MS_MAX :
	                    cmd_in.value;
	wire [23:0] dist_w = (cmd_in.value > 32'(`MSC_DIST_MAX)) ?
	                     `MSC_DIST_MAX : cmd_in.value[23:0];

	function automatic logic signed [31:0] clip_pos(
		input logic signed [63:0] v);
		if (v > 64'(`MSC_POS_LIMIT))
			clip_pos = `MSC_POS_LIMIT;
		else if (v < -64'(`MSC_POS_LIMIT))
			clip_pos = -`MSC_POS_LIMIT;
		else
			clip_pos = v[31:0];
	endfunction

	// Encoder scaled to motor steps, zero resolution gives zero
	wire signed [63:0] scaled_w = (encoder_resolution_in == 16'h0) ? 64'sd0 :
		prod_r / $signed({48'h0, encoder_resolution_in}); // [R8] [R16]
	wire signed [31:0] diff_w = clip_pos(scaled_w -
		64'(position_counter_in)); // [R8]
	wire signed [31:0] abs_w = diff_w[31] ? -diff_w : diff_w;

	assign cmd_ready_out = idle_w;
	assign step_hold_out = (state_r == MSC_ST_DELAY); // [R12]

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			MSC_ST_IDLE: begin
				if (take_w && imm_w && need_conf_w)
					state_nxt = MSC_ST_CONFIRM; // [R5] [R7] [R14]
				else if (take_w && cmd_in.op == MSC_OP_DELAY &&
				         cmd_in.from_seq)
					state_nxt = MSC_ST_DELAY; // [R13]
				else if (take_w && cmd_in.op == MSC_OP_POSCHK)
					state_nxt = MSC_ST_PCHK;
			end
			MSC_ST_CONFIRM: begin
				if (ans_evt_w)
					state_nxt = MSC_ST_DONE; // [R17]
			end
			MSC_ST_DELAY: begin
				if (ms_left_r == 32'h1 && tick_end_w)
					state_nxt = MSC_ST_DONE;
			end
			MSC_ST_PCHK: state_nxt = MSC_ST_DONE;
			MSC_ST_DONE: state_nxt = MSC_ST_IDLE;
			default: state_nxt = MSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= MSC_ST_IDLE;
			pend_r  <= '0;
			prod_r  <= '0;
		end else begin
			state_r <= state_nxt;
			if (take_w)
				pend_r <= cmd_in;
			prod_r <= 64'(encoder_counter_in) *
			          $signed({48'h0, motor_resolution_in}); // [R8]
		end
	end

	// Delay countdown in milliseconds
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ms_left_r <= '0;
			tick_r    <= '0;
		end else if (take_w && cmd_in.op == MSC_OP_DELAY) begin
			ms_left_r <= dly_w; // [R12]
			tick_r    <= '0;
		end else if (state_r == MSC_ST_DELAY) begin
			tick_r <= tick_end_w ? 16'h0 : tick_r + 16'h1;
			if (tick_end_w)
				ms_left_r <= ms_left_r - 32'h1;
		end
	end

	// Return stack
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sp_r           <= '0;
			jump_valid_out <= 1'b0;
			jump_out       <= '0;
			stack_err_out  <= 1'b0;
			for (int i = 0; i < `MSC_STACK_DEPTH; i++)
				stack_r[i] <= '0;
		end else begin
			jump_valid_out <= 1'b0;
			stack_err_out  <= 1'b0;
			if (take_w && cmd_in.op == MSC_OP_CALL && cmd_in.from_seq) begin
				if (stack_full_w) begin
					stack_err_out <= 1'b1;
				end else begin
					stack_r[sp_r[2:0]] <= '{seq: cmd_in.seq_b,
						step: cur_step_in + 8'h1}; // [R18]
					sp_r           <= sp_r + 4'h1;
					jump_out       <= '{seq: cmd_in.seq_a, step: 8'h0}; // [R1]
					jump_valid_out <= 1'b1;
				end
			end else if (take_w && cmd_in.op == MSC_OP_RETURN) begin
				if (stack_empty_w) begin
					stack_err_out <= 1'b1;
				end else begin
					jump_out       <= stack_r[sp_r[2:0] - 3'h1]; // [R1] [R18]
					sp_r           <= sp_r - 4'h1;
					jump_valid_out <= 1'b1;
				end
			end
		end
	end

	// Responses, storage strobes and motion parameters
	wire conf_done_w = (state_r == MSC_ST_CONFIRM) && ans_evt_w && ans_yes_w;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			resp_out            <= '0;
			display_loop_on_out <= 1'b0;
			wipe_out            <= 1'b0;
			copy_out            <= 1'b0;
			delete_out          <= 1'b0;
			resume_out          <= 1'b0;
			store_src_out       <= '0;
			store_dst_out       <= '0;
			distance_out        <= '0;
			dir_ccw_out         <= 1'b0;
		end else begin
			resp_out   <= '0;
			wipe_out   <= 1'b0;
			copy_out   <= 1'b0;
			delete_out <= 1'b0;
			resume_out <= 1'b0;
			if (display_loop_set_in)
				display_loop_on_out <= 1'b1;
			else if (take_w && cmd_in.op == MSC_OP_DLCLR)
				display_loop_on_out <= 1'b0; // [R3]
			if (take_w && imm_w && cmd_in.op == MSC_OP_MEMREP)
				resp_out <= '{value: 32'(`MSC_MEM_TOTAL - mem_used_in),
					text_free: 1'b1, prompt: 1'b0, valid: 1'b1}; // [R2]
			if (take_w && imm_w && need_conf_w) begin
				resp_out <= '{value: 32'sd0, text_free: 1'b0,
					prompt: 1'b1, valid: 1'b1}; // [R5] [R7] [R14]
				store_src_out <= cmd_in.seq_a;
				store_dst_out <= cmd_in.seq_b;
			end
			if (take_w && imm_w && cmd_in.op == MSC_OP_COPY &&
			    !seq_exists_in[cmd_in.seq_b]) begin
				copy_out      <= 1'b1; // [R7]
				store_src_out <= cmd_in.seq_a;
				store_dst_out <= cmd_in.seq_b;
			end
			if (conf_done_w) begin
				wipe_out   <= (pend_r.op == MSC_OP_WIPE); // [R4] [R17]
				copy_out   <= (pend_r.op == MSC_OP_COPY); // [R7] [R17]
				delete_out <= (pend_r.op == MSC_OP_DELETE); // [R14] [R17]
			end
			if (take_w && imm_w && cmd_in.op == MSC_OP_RESUME &&
			    interrupted_in)
				resume_out <= 1'b1; // [R6]
			if (state_r == MSC_ST_PCHK)
				resp_out <= '{value: pend_r.in_cond ? abs_w : diff_w,
					text_free: 1'b0, prompt: 1'b0, valid: 1'b1}; // [R9]
			if (conf_done_w && pend_r.op == MSC_OP_WIPE)
				distance_out <= '0; // [R4]
			else if (take_w && cmd_in.op == MSC_OP_DIST) begin
				distance_out <= dist_w; // [R10]
				if (cmd_in.seq_a[0])
					dir_ccw_out <= cmd_in.neg; // [R10]
			end else if (take_w && cmd_in.op == MSC_OP_DIR)
				dir_ccw_out <= cmd_in.neg; // [R11]
		end
	end
endmodule // msc_core
`default_nettype wire

// ==== tb/msc_host.sv ====
// Host terminal model that answers confirmation prompts
`default_nettype none
module msc_host (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       prompt_in,
	input  wire logic [7:0] reply_in,
	output logic            answer_valid_out,
	output logic [7:0]      answer_char_out
);
	logic [3:0] wait_r;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_r <= 4'h0;
		end else if (prompt_in) begin
			wait_r <= 4'h4;
		end else if (wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end
	end
	// Answer only after a prompt, some cycles late
	assign answer_valid_out = (wait_r == 4'h1);
	// Line shows no stale character outside the answer
	assign answer_char_out  = answer_valid_out ? reply_in : ~reply_in;
endmodule // msc_host
`default_nettype wire

// ==== tb/msc_core_checker.sv ====
// Concurrent checks on the command core ports
`include "msc_consts.svh"
`default_nettype none
module msc_core_checker (
	input wire logic                ref_clk_in,
	input wire logic                rst_b_in,
	input wire logic                cmd_valid_in,
	input wire msc_pkg::msc_cmd_t   cmd_in,
	input wire logic                cmd_ready_out,
	input wire logic                answer_valid_in,
	input wire logic [7:0]          answer_char_in,
	input wire msc_pkg::msc_resp_t  resp_out,
	input wire logic                wipe_out,
	input wire logic                step_hold_out,
	input wire logic                jump_valid_out,
	input wire msc_pkg::msc_frame_t jump_out,
	input wire logic                stack_err_out,
	input wire logic                display_loop_on_out,
	input wire logic                display_loop_set_in,
	input wire logic                dir_ccw_out
);
	import msc_pkg::*;
	logic take;
	logic yes;
	assign take = cmd_valid_in & cmd_ready_out;
	assign yes  = answer_valid_in && (answer_char_in == `MSC_ANS_YES ||
		answer_char_in == `MSC_ANS_YES_LC);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_call_jumps: assert property (take && cmd_in.op == MSC_OP_CALL &&
		cmd_in.from_seq |=> stack_err_out || (jump_valid_out &&
		jump_out.seq == $past(cmd_in.seq_a) && jump_out.step == 8'h00))
		else $error("call did not jump to the callee");
	a_wipe_prompt: assert property (take && cmd_in.op == MSC_OP_WIPE &&
		!cmd_in.from_seq |=> resp_out.valid && resp_out.prompt && !cmd_ready_out)
		else $error("wipe without prompt");
	a_wipe_seq_refused: assert property (take &&
		cmd_in.op == MSC_OP_WIPE && cmd_in.from_seq |=> !resp_out.valid ##1 !wipe_out)
		else $error("wipe accepted from a sequence");
	a_wipe_needs_yes: assert property (wipe_out |-> $past(yes))
		else $error("wipe without a yes answer");
	a_delay_holds: assert property (take && cmd_in.op == MSC_OP_DELAY &&
		cmd_in.from_seq |=> step_hold_out [*8])
		else $error("delay did not hold the next step");
	a_delay_imm_off: assert property (take && cmd_in.op == MSC_OP_DELAY &&
		!cmd_in.from_seq |=> !step_hold_out)
		else $error("immediate delay held execution");
	a_clear_stops: assert property (take && cmd_in.op == MSC_OP_DLCLR &&
		!display_loop_set_in |=> !display_loop_on_out)
		else $error("display loop still on after clear");
	a_check_latency: assert property (take &&
		cmd_in.op == MSC_OP_POSCHK |=> !resp_out.valid ##1 resp_out.valid)
		else $error("position check answer late or early");
	a_dist_dir: assert property (take && cmd_in.op == MSC_OP_DIST &&
		cmd_in.seq_a[0] |=> dir_ccw_out == $past(cmd_in.neg))
		else $error("signed distance did not set direction");
	cover property (take && cmd_in.op == MSC_OP_WIPE);
	cover property (wipe_out);
	cover property (step_hold_out);
endmodule // msc_core_checker
bind msc_core msc_core_checker i_chk (.ref_clk_in, .rst_b_in, .cmd_valid_in,
	.cmd_in, .cmd_ready_out, .answer_valid_in, .answer_char_in, .resp_out,
	.wipe_out, .step_hold_out, .jump_valid_out, .jump_out, .stack_err_out,
	.display_loop_on_out, .display_loop_set_in, .dir_ccw_out);
`default_nettype wire

// ==== tb/msc_core_bench.sv ====
// Self-checking bench of the motion sequence command core
`default_nettype none
module msc_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import msc_pkg::*;
	logic ref_clk_in = 1'b0, rst_b_in = 1'b0, cmd_valid_in = 1'b0;
	logic interrupted_in = 1'b1, display_loop_set_in = 1'b0;
	msc_cmd_t cmd_in = '0;
	logic [7:0] cur_step_in = 8'h03, reply = 8'h4e, answer_char_in;
	logic signed [31:0] encoder_counter_in = 32'h7d0;
	logic signed [31:0] position_counter_in = 32'h1f5;
	logic [15:0] motor_resolution_in = 16'h1f4, encoder_resolution_in = 16'h7d0;
	logic [15:0] mem_used_in = 16'h0100;
	logic [63:0] seq_exists_in = 64'h400;
	logic cmd_ready_out, answer_valid_in, jump_valid_out, stack_err_out;
	logic display_loop_on_out, wipe_out, copy_out, delete_out, resume_out;
	logic dir_ccw_out, step_hold_out;
	logic [5:0] store_src_out, store_dst_out;
	logic [23:0] distance_out;
	msc_resp_t resp_out;
	msc_frame_t jump_out;
	int bad_count = 0, check_count = 0, n_wipe = 0, n_copy = 0, n_del = 0;
	always #10 ref_clk_in = ~ref_clk_in;
	msc_core i_dut (.ref_clk_in, .rst_b_in, .cmd_valid_in, .cmd_in,
		.cmd_ready_out, .answer_valid_in, .answer_char_in, .cur_step_in,
		.encoder_counter_in, .position_counter_in, .motor_resolution_in,
		.encoder_resolution_in, .interrupted_in, .mem_used_in, .resp_out,
		.jump_out, .jump_valid_out, .stack_err_out, .display_loop_on_out,
		.display_loop_set_in, .wipe_out, .copy_out, .delete_out,
		.store_src_out, .store_dst_out, .seq_exists_in, .resume_out,
		.distance_out, .dir_ccw_out, .step_hold_out);
	msc_host i_host (.ref_clk_in, .rst_b_in,
		.prompt_in(resp_out.valid & resp_out.prompt), .reply_in(reply),
		.answer_valid_out(answer_valid_in), .answer_char_out(answer_char_in));
	always @(negedge ref_clk_in) begin
		if (wipe_out === 1'b1) n_wipe++;
		if (copy_out === 1'b1) n_copy++;
		if (delete_out === 1'b1) n_del++;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] g, logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic idle;
		int i;
		for (i = 0; i < 300 && cmd_ready_out !== 1'b1; i++)
			@(posedge ref_clk_in) #1;
		if (i == 300) begin
			bad_count++;
			finish_test();
		end
		@(posedge ref_clk_in) #1;
	endtask
	task automatic issue(msc_cmd_t c);
		idle();
		cmd_in = c;
		cmd_valid_in = 1'b1;
		@(posedge ref_clk_in) #1;
		cmd_valid_in = 1'b0;
	endtask
	task automatic t_call;
		issue('{MSC_OP_RETURN, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("ret_empty", stack_err_out, 1'b1);
		issue('{MSC_OP_CALL, 1'b1, 1'b0, 1'b0, 6'd5, 6'd2, 32'h0});
		chk("call1", jump_out, 14'h500);
		chk("call1_valid", jump_valid_out, 1'b1);
		cur_step_in = 8'h01;
		issue('{MSC_OP_CALL, 1'b1, 1'b0, 1'b0, 6'd7, 6'd5, 32'h0});
		chk("call2", jump_out, 14'h700);
		issue('{MSC_OP_RETURN, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("ret1", jump_out, 14'h502);
		issue('{MSC_OP_RETURN, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("ret2", jump_out, 14'h204);
	endtask
	task automatic t_confirm;
		issue('{MSC_OP_WIPE, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("wipe_seq", resp_out.valid, 1'b0);
		issue('{MSC_OP_WIPE, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("wipe_prompt", resp_out.prompt, 1'b1);
		idle();
		chk("wipe_no", n_wipe, 0);
		issue('{MSC_OP_DIST, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h10});
		chk("dist_set", distance_out, 24'h10);
		reply = 8'h59;
		issue('{MSC_OP_WIPE, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		idle();
		chk("wipe_yes", n_wipe, 1);
		chk("wipe_dist", distance_out, 24'h0);
		issue('{MSC_OP_COPY, 1'b0, 1'b0, 1'b0, 6'd5, 6'd10, 32'h0});
		chk("copy_prompt", resp_out.prompt, 1'b1);
		idle();
		chk("copy_done", n_copy, 1);
		chk("copy_pair", {store_src_out, store_dst_out}, 12'h14a);
		issue('{MSC_OP_COPY, 1'b0, 1'b0, 1'b0, 6'd5, 6'd11, 32'h0});
		chk("copy_new", copy_out, 1'b1);
		reply = 8'h79;
		issue('{MSC_OP_DELETE, 1'b0, 1'b0, 1'b0, 6'd49, 6'd0, 32'h0});
		chk("del_prompt", resp_out.prompt, 1'b1);
		idle();
		chk("del_done", n_del, 1);
	endtask
	task automatic t_values;
		issue('{MSC_OP_MEMREP, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("mem_text", resp_out.text_free, 1'b1);
		chk("mem_free", resp_out.value, 32'h1f00);
		issue('{MSC_OP_POSCHK, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		@(posedge ref_clk_in) #1;
		chk("pos_signed", resp_out.value, 32'hffffffff);
		issue('{MSC_OP_POSCHK, 1'b1, 1'b1, 1'b0, 6'd0, 6'd0, 32'h0});
		@(posedge ref_clk_in) #1;
		chk("pos_abs", resp_out.value, 32'h1);
		issue('{MSC_OP_DIST, 1'b0, 1'b0, 1'b1, 6'd1, 6'd0, 32'h989680});
		chk("dist_max", {dir_ccw_out, distance_out}, 25'h198967f);
		issue('{MSC_OP_DIR, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("dir_cw", dir_ccw_out, 1'b0);
		issue('{MSC_OP_RESUME, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("resume_seq", resume_out, 1'b0);
		issue('{MSC_OP_RESUME, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("resume", resume_out, 1'b1);
		display_loop_set_in = 1'b1;
		@(posedge ref_clk_in) #1;
		display_loop_set_in = 1'b0;
		chk("loop_set", display_loop_on_out, 1'b1);
		issue('{MSC_OP_DLCLR, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h0});
		chk("loop_clear", display_loop_on_out, 1'b0);
	endtask
	task automatic t_delay;
		int n;
		issue('{MSC_OP_DELAY, 1'b0, 1'b0, 1'b0, 6'd0, 6'd0, 32'h1});
		chk("hold_imm", step_hold_out, 1'b0);
		issue('{MSC_OP_DELAY, 1'b1, 1'b0, 1'b0, 6'd0, 6'd0, 32'h1});
		for (n = 0; n < 60000 && step_hold_out === 1'b1; n++)
			@(posedge ref_clk_in) #1;
		chk("hold_cycles", n, 50000);
		if (n == 60000)
			finish_test();
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_in);
		#1 rst_b_in = 1'b1;
		t_call();
		t_confirm();
		t_values();
		t_delay();
		finish_test();
	end
endmodule // msc_core_bench
`default_nettype wire
